// >>> rtl/port_crossbar_pkg.sv
// shared constants and carrier types for the port 0 crossbar and data latch
package port_crossbar_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] ADDR_PORT0_DATA  = 8'h80;
  localparam logic [7:0] ADDR_ROUTE_EN_A  = 8'hE2;
  localparam logic [7:0] ADDR_ROUTE_EN_B  = 8'hE3;
  // bit addresses of the port data register occupy 0x80..0x87
  localparam logic [4:0] BIT_BASE_PORT0   = 5'h10;

  // reset values
  localparam logic [7:0] RST_PORT0_DATA   = 8'hFF;
  localparam logic [7:0] RST_ROUTE_EN_A   = 8'h00;
  localparam logic [7:0] RST_ROUTE_EN_B   = 8'h00;

  // field positions, route enables a
  localparam int POS_CAPTURE_SEL_LO = 6;
  localparam int POS_CMP_ASYNC      = 5;
  localparam int POS_CMP_SYNC       = 4;
  localparam int POS_SYSCLK         = 3;
  localparam int POS_TWO_WIRE       = 2;
  localparam int POS_UART_RX        = 1;
  localparam int POS_UART_TX        = 0;
  // field positions, route enables b
  localparam int POS_WEAK_PUD       = 7;
  localparam int POS_XBAR_EN        = 6;
  localparam int POS_TIMER1         = 2;
  localparam int POS_TIMER0         = 1;
  localparam int POS_COUNTER_CLK    = 0;
  localparam logic [7:0] MASK_ROUTE_EN_B = 8'hC7;

  // fixed uart pins
  localparam int PIN_UART_TX = 4;
  localparam int PIN_UART_RX = 5;

  // crossbar signals in priority order; SIG_NONE marks an unrouted pin
  localparam int NUM_SIG = 11;
  localparam logic [3:0] SIG_SDA   = 4'h0;
  localparam logic [3:0] SIG_SCL   = 4'h1;
  localparam logic [3:0] SIG_CPS   = 4'h2;
  localparam logic [3:0] SIG_CPA   = 4'h3;
  localparam logic [3:0] SIG_SYSCK = 4'h4;
  localparam logic [3:0] SIG_CAPTURE_MODULE_IO_ZERO  = 4'h5;
  localparam logic [3:0] SIG_CAPTURE_MODULE_IO_ONE  = 4'h6;
  localparam logic [3:0] SIG_CAPTURE_MODULE_IO_TWO  = 4'h7;
  localparam logic [3:0] SIG_ECI   = 4'h8;
  localparam logic [3:0] SIG_T0    = 4'h9;
  localparam logic [3:0] SIG_T1    = 4'hA;
  localparam logic [3:0] SIG_NONE  = 4'hB;

  // levels driven by on-chip peripherals towards the pins
  typedef struct packed {
    logic       uart_tx;
    logic       sda;
    logic       scl;
    logic       cmp_sync;
    logic       cmp_async;
    logic       sysclk;
    logic [2:0] cex;
  } periph_out_t;

  // levels returned from the pins to the peripherals
  typedef struct packed {
    logic       uart_rx;
    logic       sda;
    logic       scl;
    logic [2:0] cex;
    logic       counter_clk;
    logic       timer0;
    logic       timer1;
  } periph_in_t;

endpackage

// >>> rtl/port_crossbar.sv
// port 0 crossbar routing, pin drivers and port data latch
`timescale 1ns/10ps
`default_nettype none

// Contract
// (RL1) uart receive taken from pin 5 when enabled
// (RL2) uart transmit driven on pin 4 when enabled
// (RL3) two-wire enable routes data and clock together
// (RL4) capture field routes none, one, two, three modules
// (RL5) single-bit enables route their own signal
// (RL6) crossbar off: all pins plain inputs
// (RL7) crossbar off: output drivers disabled
// (RL8) weak pullup on open-drain pins unless driving low
// (RL9) leftover unskipped pins are ordinary port pins
// (RL10) data register byte and bit accessible
// (RL11) writes store bits in output latch
// (RL12) ordinary read returns pin levels
// (RL13) read-modify-write reads the latch instead
// (RL14) byte logic and arithmetic ops read the latch
// (RL15) bit move, clear, set read the latch
// (RL16) software should skip pins used elsewhere
// (RL17) software selects analog or digital mode
// (RL18) software selects open-drain or push-pull
// (RL19) two-wire pins forced open-drain
module port_crossbar
  import port_crossbar_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // byte register port
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr_en,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_sfr_rd_en,
  input  wire logic        i_sfr_rmw,
  output logic      [7:0]  o_sfr_rdata,
  // bit register port
  input  wire logic [7:0]  i_bit_addr,
  input  wire logic        i_bit_wr_en,
  input  wire logic        i_bit_wdata,
  input  wire logic        i_bit_rd_en,
  input  wire logic        i_bit_rmw,
  output logic             o_bit_rdata,
  // port configuration held elsewhere
  input  wire logic [7:0]  i_skip,
  input  wire logic [7:0]  i_input_mode,
  input  wire logic [7:0]  i_output_mode,
  // peripherals
  input  wire periph_out_t i_periph,
  output periph_in_t       o_periph,
  // pins
  input  wire logic [7:0]  i_pin,
  output logic      [7:0]  o_pin,
  output logic      [7:0]  o_pin_oe,
  output logic      [7:0]  o_pin_pullup
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] latch_r;
  logic [7:0] route_a_r;
  logic [7:0] route_b_r;

  wire xbar_en  = route_b_r[POS_XBAR_EN];
  wire weak_pud = route_b_r[POS_WEAK_PUD];
  wire uart_tx_en = xbar_en & route_a_r[POS_UART_TX];
  wire uart_rx_en = xbar_en & route_a_r[POS_UART_RX];
  wire [1:0] cap_sel = route_a_r[POS_CAPTURE_SEL_LO +: 2];

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire wr_latch = i_sfr_wr_en && (i_sfr_addr == ADDR_PORT0_DATA);
  wire wr_a     = i_sfr_wr_en && (i_sfr_addr == ADDR_ROUTE_EN_A);
  wire wr_b     = i_sfr_wr_en && (i_sfr_addr == ADDR_ROUTE_EN_B);
  wire bit_hit  = (i_bit_addr[7:3] == BIT_BASE_PORT0);
  wire [2:0] bit_idx = i_bit_addr[2:0];

  // latch source for read-modify-write, pins otherwise
  wire [7:0] port_view = i_sfr_rmw ? latch_r : i_pin;  // see (RL12) (RL13) (RL14)
  wire [7:0] rd_mux =
    (i_sfr_addr == ADDR_PORT0_DATA) ? port_view :
    (i_sfr_addr == ADDR_ROUTE_EN_A) ? route_a_r :
    (i_sfr_addr == ADDR_ROUTE_EN_B) ? (route_b_r & MASK_ROUTE_EN_B) : 8'h00;
  wire bit_rd_mux = bit_hit & (i_bit_rmw ? latch_r[bit_idx] : i_pin[bit_idx]);  // see (RL15)

  // bit writes merge into the byte; a byte write in the same cycle wins
  logic [7:0] latch_nxt;
  always_comb
  begin
    latch_nxt = latch_r;
    if (i_bit_wr_en && bit_hit)
      latch_nxt[bit_idx] = i_bit_wdata;  // see (RL10)
    if (wr_latch)
      latch_nxt = i_sfr_wdata;  // see (RL11)
  end

  // register storage and read data
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      latch_r     <= RST_PORT0_DATA;
      route_a_r   <= RST_ROUTE_EN_A;
      route_b_r   <= RST_ROUTE_EN_B;
      o_sfr_rdata <= 8'h00;
      o_bit_rdata <= 1'b0;
    end
    else
    begin
      latch_r <= latch_nxt;  // see (RL11)
      if (wr_a)
        route_a_r <= i_sfr_wdata;
      if (wr_b)
        route_b_r <= i_sfr_wdata & MASK_ROUTE_EN_B;  // unused bits read zero
      if (i_sfr_rd_en)
        o_sfr_rdata <= rd_mux;
      if (i_bit_rd_en)
        o_bit_rdata <= bit_rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // priority decoder
  // request vector in priority order; both two-wire lines share one enable
  wire [NUM_SIG-1:0] req = xbar_en ? {
    route_b_r[POS_TIMER1],                                      // see (RL5)
    route_b_r[POS_TIMER0],
    route_b_r[POS_COUNTER_CLK],
    cap_sel == 2'b11,                                           // see (RL4)
    cap_sel[1],
    cap_sel != 2'b00,
    route_a_r[POS_SYSCLK],
    route_a_r[POS_CMP_ASYNC],
    route_a_r[POS_CMP_SYNC],
    route_a_r[POS_TWO_WIRE],                                    // see (RL3)
    route_a_r[POS_TWO_WIRE]} : '0;                              // see (RL6)

  // enabled uart pins are fixed, so the decoder passes over them
  wire [7:0] blocked = i_skip
    | (uart_tx_en ? 8'h10 : 8'h00)
    | (uart_rx_en ? 8'h20 : 8'h00);

  // walk pins upward handing out requested signals in priority order
  function automatic logic [31:0] place(input logic [NUM_SIG-1:0] r, input logic [7:0] blk);
    logic [31:0] res;
    logic [3:0]  s;
    res = {8{SIG_NONE}};
    s   = 4'h0;
    for (int p = 0; p < 8; p++)
    begin
      while (s < SIG_NONE && !r[s])
        s = s + 4'h1;
      if (!blk[p] && s < SIG_NONE)
      begin
        res[4*p +: 4] = s;
        s = s + 4'h1;
      end
    end
    return res;
  endfunction

  wire [31:0] sel = place(req, blocked);  // see (RL9)

  ////////////////////////////////////////////////////////////////////////
  // pin drivers
  logic [7:0] pin_nxt;
  logic [7:0] oe_nxt;
  logic [7:0] pu_nxt;
  periph_in_t in_nxt;

  always_comb
  begin
    logic [3:0] s;
    logic       val;
    logic       od;
    pin_nxt = 8'h00;
    oe_nxt  = 8'h00;
    pu_nxt  = 8'h00;
    s       = SIG_NONE;
    val     = 1'b1;
    od      = 1'b1;
    in_nxt  = '1;  // idle level for unrouted inputs
    for (int p = 0; p < 8; p++)
    begin
      s   = sel[4*p +: 4];
      val = latch_r[p];
      od  = !i_output_mode[p];  // see (RL18)
      if (p == PIN_UART_TX && uart_tx_en)
        val = i_periph.uart_tx;  // see (RL2)
      case (s)
        SIG_SDA:   begin val = i_periph.sda;       od = 1'b1; in_nxt.sda = i_pin[p]; end  // see (RL19)
        SIG_SCL:   begin val = i_periph.scl;       od = 1'b1; in_nxt.scl = i_pin[p]; end  // see (RL19)
        SIG_CPS:   val = i_periph.cmp_sync;
        SIG_CPA:   val = i_periph.cmp_async;
        SIG_SYSCK: val = i_periph.sysclk;
        SIG_CAPTURE_MODULE_IO_ZERO:  begin val = i_periph.cex[0]; in_nxt.cex[0] = i_pin[p]; end
        SIG_CAPTURE_MODULE_IO_ONE:  begin val = i_periph.cex[1]; in_nxt.cex[1] = i_pin[p]; end
        SIG_CAPTURE_MODULE_IO_TWO:  begin val = i_periph.cex[2]; in_nxt.cex[2] = i_pin[p]; end
        SIG_ECI:   in_nxt.counter_clk = i_pin[p];
        SIG_T0:    in_nxt.timer0 = i_pin[p];
        SIG_T1:    in_nxt.timer1 = i_pin[p];
        default:   ;
      endcase
      if (xbar_en && i_input_mode[p])  // analog cells never drive
      begin
        pin_nxt[p] = od ? 1'b0 : val;
        oe_nxt[p]  = od ? !val : 1'b1;  // see (RL7)
      end
      // pullup only on digital open-drain cells not pulling low
      pu_nxt[p] = !weak_pud && i_input_mode[p] && od && !oe_nxt[p];  // see (RL8)
    end
    if (uart_rx_en)
      in_nxt.uart_rx = i_pin[PIN_UART_RX];  // see (RL1)
  end

  // registered pin and peripheral side; costs one cycle of latency each way
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_pin        <= 8'h00;
      o_pin_oe     <= 8'h00;
      o_pin_pullup <= 8'h00;
      o_periph     <= '1;
    end
    else
    begin
      o_pin        <= pin_nxt;
      o_pin_oe     <= oe_nxt;
      o_pin_pullup <= pu_nxt;
      o_periph     <= in_nxt;
    end
  end

endmodule // port_crossbar

`default_nettype wire

// >>> tb/pin_board.sv
// board side of the port pins
`timescale 1ns/10ps
`default_nettype none
module pin_board (
  // device and board drive
  input  wire logic [7:0] i_drv,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  output logic      [7:0] o_level
);
  // an enabled device driver wins; otherwise the board source holds the line
  assign o_level = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule // pin_board
`default_nettype wire

// >>> tb/port_crossbar_assertions.sv
// port-level checks for the crossbar
`timescale 1ns/10ps
`default_nettype none
module port_crossbar_assertions
  import port_crossbar_pkg::*;
(
  // watched ports
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr_en,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_sfr_rd_en,
  input wire logic        i_sfr_rmw,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic [7:0]  i_input_mode,
  input wire logic [7:0]  i_output_mode,
  input wire periph_out_t i_periph,
  input wire periph_in_t  o_periph,
  input wire logic [7:0]  i_pin,
  input wire logic [7:0]  o_pin,
  input wire logic [7:0]  o_pin_oe,
  input wire logic [7:0]  o_pin_pullup
);
  logic       xen_r;
  logic       tw_r;
  logic [1:0] uart_r;
  wire        wr_a = i_sfr_wr_en && i_sfr_addr == ADDR_ROUTE_EN_A;
  wire        wr_b = i_sfr_wr_en && i_sfr_addr == ADDR_ROUTE_EN_B;
  wire        rd_p = i_sfr_rd_en && i_sfr_addr == ADDR_PORT0_DATA;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // shadow of the enables; pin checks need them, the ports do not show them
  always_ff @(posedge i_clk_sys)
    if (!i_rst_n)
      {xen_r, tw_r, uart_r} <= 4'h0;
    else if (wr_a)
      {tw_r, uart_r} <= i_sfr_wdata[2:0];
    else if (wr_b)
      xen_r <= i_sfr_wdata[POS_XBAR_EN];
  a_off_no_drive: assert property (!xen_r |=> o_pin_oe == 8'h00)
    else $error("pin driven while crossbar off");
  a_off_inputs_idle: assert property (!xen_r |=> &o_periph)
    else $error("peripheral input routed while crossbar off");
  a_tx_on_pin4: assert property (xen_r && uart_r[0] && i_input_mode[4] && i_output_mode[4]
    |=> o_pin_oe[4] && o_pin[4] == $past(i_periph.uart_tx)) else $error("uart transmit not on pin 4");
  a_rx_from_pin5: assert property (xen_r && uart_r[1] && i_input_mode[5]
    |=> o_periph.uart_rx == $past(i_pin[5])) else $error("uart receive not from pin 5");
  a_rx_unrouted: assert property (!uart_r[1] |=> o_periph.uart_rx)
    else $error("uart receive reaches a pin while disabled");
  a_read_pin_level: assert property (rd_p && !i_sfr_rmw && i_input_mode == 8'hFF
    |=> o_sfr_rdata == $past(i_pin)) else $error("data read is not the pin level");
  // two-wire pins are forced open-drain, so their mode bits say nothing while that route is on
  a_pullup_od_only: assert property ((o_pin_pullup & (o_pin_oe | ~$past(i_input_mode)
    | ($past(tw_r) ? 8'h00 : $past(i_output_mode)))) == 8'h00)
    else $error("pullup on a driven, analog or push-pull pin");
  a_route_b_unused: assert property (i_sfr_rd_en && i_sfr_addr == ADDR_ROUTE_EN_B
    |=> o_sfr_rdata[5:3] == 3'h0) else $error("unused route b bits read nonzero");
endmodule // port_crossbar_assertions
bind port_crossbar port_crossbar_assertions i_chk (.i_clk_sys, .i_rst_n, .i_sfr_addr, .i_sfr_wr_en,
  .i_sfr_wdata, .i_sfr_rd_en, .i_sfr_rmw, .o_sfr_rdata, .i_input_mode, .i_output_mode, .i_periph,
  .o_periph, .i_pin, .o_pin, .o_pin_oe, .o_pin_pullup);
`default_nettype wire

// >>> tb/test_port_crossbar.sv
// self-checking bench for the port crossbar and data latch
`timescale 1ns/10ps
`default_nettype none
module test_port_crossbar;
  import port_crossbar_pkg::*;
  logic        i_clk_sys, i_rst_n, i_sfr_wr_en, i_sfr_rd_en, i_sfr_rmw, o_bit_rdata;
  logic        i_bit_wr_en, i_bit_wdata, i_bit_rd_en, i_bit_rmw;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_bit_addr, i_skip, ext;
  logic [7:0]  i_input_mode, i_output_mode, i_pin, o_pin, o_pin_oe, o_pin_pullup;
  periph_out_t i_periph;
  periph_in_t  o_periph;
  int          err_count, total_checks;
  logic [7:0]  ra [7] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h10, 8'h20, 8'h08};
  logic [7:0]  pa [7] = '{8'hFF, 8'hFE, 8'hFC, 8'hF8, 8'hFE, 8'hFE, 8'hFE};
  logic [7:0]  rb [3] = '{8'h41, 8'h42, 8'h44};
  logic [7:0]  pb [3] = '{8'hFB, 8'hFD, 8'hFE};
  port_crossbar i_dut (.i_clk_sys, .i_rst_n, .i_sfr_addr, .i_sfr_wr_en, .i_sfr_wdata, .i_sfr_rd_en,
    .i_sfr_rmw, .o_sfr_rdata, .i_bit_addr, .i_bit_wr_en, .i_bit_wdata, .i_bit_rd_en, .i_bit_rmw,
    .o_bit_rdata, .i_skip, .i_input_mode, .i_output_mode, .i_periph, .o_periph, .i_pin, .o_pin,
    .o_pin_oe, .o_pin_pullup);
  pin_board i_board (.i_drv(o_pin), .i_oe(o_pin_oe), .i_ext(ext), .o_level(i_pin));
  // 20 MHz system clock
  always #25 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // strobe is dropped for two cycles so no access merges with the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr_en = 1'b1;
    tick(1);
    i_sfr_wr_en = 1'b0;
    tick(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input string n);
    i_sfr_addr = a;
    i_sfr_rmw = m;
    i_sfr_rd_en = 1'b1;
    tick(1);
    i_sfr_rd_en = 1'b0;
    chk(n, e, o_sfr_rdata);
    tick(1);
  endtask
  task automatic bit_acc(input logic [7:0] a, input logic w, input logic m, input logic d);
    i_bit_addr = a;
    i_bit_rmw = m;
    i_bit_wdata = d;
    i_bit_wr_en = w;
    i_bit_rd_en = !w;
    tick(1);
    {i_bit_wr_en, i_bit_rd_en} = 2'b00;
    if (!w)
      chk("bit", {7'h00, d}, {7'h00, o_bit_rdata});
    tick(1);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // guard against a hung run
  initial
  begin
    #1000000;
    err_count++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {i_clk_sys, i_rst_n, i_sfr_wr_en, i_sfr_rd_en, i_sfr_rmw} = 5'h00;
    {i_bit_wr_en, i_bit_wdata, i_bit_rd_en, i_bit_rmw, i_periph} = '0;
    {i_sfr_addr, i_sfr_wdata, i_bit_addr, i_skip} = '0;
    {err_count, total_checks} = 0;
    ext = 8'h3C;
    i_input_mode = 8'hFF;
    i_output_mode = 8'h00;
    tick(20);
    i_rst_n = 1'b1;
    rd(ADDR_ROUTE_EN_A, 1'b0, 8'h00, "route_a");
    rd(8'h55, 1'b0, 8'h00, "unmapped");
    rd(ADDR_PORT0_DATA, 1'b1, 8'hFF, "latch");
    // crossbar still off: nothing routed, open-drain pullups on
    wr(ADDR_ROUTE_EN_A, 8'hFF);
    chk("oe_off", 8'h00, o_pin_oe);
    chk("periph_off", 8'hFF, o_periph[7:0]);
    chk("pullup", 8'hFF, o_pin_pullup);
    wr(ADDR_ROUTE_EN_B, 8'hB8);
    rd(ADDR_ROUTE_EN_B, 1'b0, 8'h80, "route_b");
    chk("pullup_off", 8'h00, o_pin_pullup);
    $display("test reset_and_off done");
    // latch against pin level, byte and bit
    wr(ADDR_PORT0_DATA, 8'hA5);
    rd(ADDR_PORT0_DATA, 1'b1, 8'hA5, "latch_rmw");
    rd(ADDR_PORT0_DATA, 1'b0, 8'h3C, "pins");
    bit_acc(8'h80, 1'b1, 1'b0, 1'b0);
    rd(ADDR_PORT0_DATA, 1'b1, 8'hA4, "bit_write");
    bit_acc(8'h80, 1'b0, 1'b1, 1'b0);
    bit_acc(8'h82, 1'b0, 1'b0, 1'b1);
    $display("test latch done");
    // two-wire pair on pins 0 and 1, forced open-drain over push-pull
    i_output_mode = 8'hFF;
    i_periph.scl = 1'b1;
    wr(ADDR_ROUTE_EN_A, 8'h04);
    wr(ADDR_ROUTE_EN_B, 8'h40);
    chk("tw_oe", 8'hFD, o_pin_oe);
    chk("tw_pin", 8'hA4, o_pin);
    wr(ADDR_ROUTE_EN_A, 8'h00);
    chk("gpio_oe", 8'hFF, o_pin_oe);
    $display("test two_wire done");
    // output routes fill pins from 0 upwards ahead of port data
    i_periph = '0;
    wr(ADDR_PORT0_DATA, 8'hFF);
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_ROUTE_EN_A, ra[i]);
      chk("route_pins", pa[i], o_pin);
    end
    // input routes read pin 0, held low by the latch
    wr(ADDR_ROUTE_EN_A, 8'h00);
    bit_acc(8'h80, 1'b1, 1'b0, 1'b0);
    for (int j = 0; j < 3; j++)
    begin
      wr(ADDR_ROUTE_EN_B, rb[j]);
      chk("in_route", pb[j], o_periph[7:0]);
    end
    $display("test routes done");
    // uart on fixed pins 4 and 5
    wr(ADDR_ROUTE_EN_B, 8'h40);
    i_output_mode = 8'h10;
    i_periph.uart_tx = 1'b1;
    wr(ADDR_ROUTE_EN_A, 8'h03);
    chk("tx_high", 8'h10, o_pin & o_pin_oe & 8'h10);
    i_periph.uart_tx = 1'b0;
    ext = 8'h1C;
    tick(3);
    chk("tx_low", 8'h10, ~o_pin & o_pin_oe & 8'h10);
    chk("rx", 8'h00, {7'h00, o_periph.uart_rx});
    wr(ADDR_ROUTE_EN_A, 8'h01);
    chk("rx_off", 8'h01, {7'h00, o_periph.uart_rx});
    $display("test uart done");
    // skipped pins and an analog cell: routed signals move up past the skipped pins
    i_skip = 8'h05;
    i_input_mode = 8'h7F;
    i_output_mode = 8'h3F;
    i_periph.scl = 1'b1;
    i_periph.sysclk = 1'b1;
    wr(ADDR_ROUTE_EN_A, 8'h1C);
    chk("skip_pin", 8'h24, o_pin);
    chk("skip_oe", 8'h37, o_pin_oe);
    chk("skip_pullup", 8'h48, o_pin_pullup);
    $display("test skip done");
    complete_run();
  end
endmodule // test_port_crossbar
`default_nettype wire
